// ==== nvac_pkg.sv ====
package nvac_pkg;
    // Register offsets (core special function register space)
    localparam logic [8:0] NVAC_OFS_CTRL = 9'h18C;
    localparam logic [8:0] NVAC_OFS_UNLOCK = 9'h18D;
    localparam logic [8:0] NVAC_OFS_DATA_LO = 9'h10C;
    localparam logic [8:0] NVAC_OFS_ADDR_LO = 9'h10D;
    localparam logic [8:0] NVAC_OFS_DATA_HI = 9'h10E;
    localparam logic [8:0] NVAC_OFS_ADDR_HI = 9'h10F;
    localparam logic [8:0] NVAC_OFS_FLAGS2 = 9'h00D;
    // Control register bit positions, then the done bit of FLAGS2
    localparam int NVAC_BIT_RD = 0;
    localparam int NVAC_BIT_WR = 1;
    localparam int NVAC_BIT_WALLOW = 2;
    localparam int NVAC_BIT_ABORT = 3;
    localparam int NVAC_BIT_ERASE = 4;
    localparam int NVAC_BIT_SPACE = 7;
    localparam int NVAC_BIT_DONE = 4;
    // Unlock key bytes, written in order to the unlock port
    localparam logic [7:0] NVAC_KEY1 = 8'h55;
    localparam logic [7:0] NVAC_KEY2 = 8'hAA;
    // Reset values
    localparam logic [7:0] NVAC_RST_BYTE = 8'h00;
    // Geometry
    localparam int NVAC_ROW_WORDS = 32;
    localparam int NVAC_BLOCK_WORDS = 4;
    // Program cycle timing
    localparam int NVAC_CLK_MHZ = 250;
    localparam int NVAC_WRITE_US = 2;
    localparam int NVAC_WRITE_CYCLES = NVAC_WRITE_US * NVAC_CLK_MHZ;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
        logic [7:0] wdata;
    } nvac_sfr_t;

    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [13:0] wdata;
    } nvac_mem_t;
endpackage

// ==== nvac_store.sv ====
`timescale 1ns/10ps
module nvac_store
    import nvac_pkg::*;
#(
    parameter int AW = 12,
    parameter int DW = 14
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule

// ==== nvac_top.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Data space uses low data byte as value, low address as byte location.
// - Small variant: data bytes 80h-FFh unimplemented and read as zero.
// - Writes to unimplemented data bytes program nothing; pump stays off.
// - Program space joins data pair into 14 bits, address pair into 13.
// - Program memory is 1K or 2K words; higher addresses wrap.
// - Data byte writes erase then program the location.
// - Program words read singly; row erase 32 words, write 4-word blocks.
// - Internal timer times each write or erase; pump generated inside.
// - Code protection keeps core reads; with it set, program writes obey write-protect.
// - Code protection blocks external programmer access and enables write-protect.
// - Address bits above memory size are stored and read back but ignored by the memory.
// - Space select clear means data, set means program; reset clears.
// - Read and write triggers set-only; hardware clears on completion.
// - Writes need write-allow, which is clear at power-up.
// - External or watchdog reset during a write sets write-abort flag.
// - Data and address registers survive that reset for a retry.
// - Write completion sets done flag; software clears it.
// - Unlock port has no storage and reads zero.
// - Row-erase select makes next program-space trigger erase the addressed row.
// - Abort flag reads zero after normal completion, one after abort.
module nvac_top
    import nvac_pkg::*;
#(
    parameter bit BIG_DATA = 1'b1,
    parameter bit BIG_PROG = 1'b1,
    parameter int WRITE_CYCLES = NVAC_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic ce,
    input wire nvac_sfr_t sfr,
    input wire logic codeProtect,
    input wire logic [3:0] blockProtect,
    input wire logic extProgRequest,
    output logic [7:0] rdData,
    output logic busy,
    output logic pumpOn,
    output logic doneFlag,
    output logic extProgGrant
);
    typedef enum logic [3:0] {
        NVAC_IDLE = 4'b0001,
        NVAC_READ = 4'b0010,
        NVAC_PROG = 4'b0100,
        NVAC_DONE = 4'b1000
    } nvac_state_t;

    logic rstMeta, rstSync, porMeta, porSync;
    nvac_state_t state;
    logic spaceSel, eraseSel, writeAllow, abortFlag, rdTrig, wrTrig;
    logic [7:0] dataLo, addrLo;
    logic [5:0] dataHi;
    logic [4:0] addrHi;
    logic [1:0] unlockStep;
    logic [31:0] timer;
    logic [4:0] rowIdx;
    logic [13:0] latch [0:3];
    logic [13:0] memRd;
    nvac_mem_t dMem, pMem;
    logic [7:0] dRd;
    logic [13:0] pRd;

    // Small variant: upper data half is absent, reads zero and never programs
    function automatic logic dataImpl(input logic [7:0] a);
        return BIG_DATA || !a[7];
    endfunction

    function automatic logic [10:0] progAddr(input logic [4:0] h, input logic [7:0] l);
        logic [12:0] full;
        full = {h, l};
        return BIG_PROG ? full[10:0] : {1'b0, full[9:0]};
    endfunction

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            porMeta <= 1'b0;
            porSync <= 1'b0;
        end else begin
            porMeta <= 1'b1;
            porSync <= porMeta;
        end
    end

    wire logic sfrWr = sfr.wr && ce;
    wire logic ctrlWr = sfrWr && sfr.addr == NVAC_OFS_CTRL;
    // Any other bus write between the keys breaks the sequence
    wire logic unlocked = unlockStep == 2'd2;
    wire logic [10:0] pAddr = progAddr(addrHi, addrLo);
    wire logic blockDenied = codeProtect && blockProtect[pAddr[10:9]];
    // Denied blocks still run the timer so software sees a normal finish
    // Pump only for cycles that program: an erase or the closing word of a block
    wire logic progFires = !blockDenied && (eraseSel || pAddr[1:0] == 2'd3);
    wire logic wrStart = ctrlWr && sfr.wdata[NVAC_BIT_WR] && !wrTrig
        && writeAllow && unlocked;
    wire logic timerEnd = timer == 32'(WRITE_CYCLES - 1);

    // Unlock: key1 then key2 on the unlock port, then WR in the next write
    always_ff @(posedge clk or negedge porSync) begin
        if (!porSync) begin
            unlockStep <= 2'd0;
        end else if (!rstSync) begin
            unlockStep <= 2'd0;
        end else if (sfrWr) begin
            if (sfr.addr == NVAC_OFS_UNLOCK && sfr.wdata == NVAC_KEY1) begin
                unlockStep <= 2'd1;
            end else if (sfr.addr == NVAC_OFS_UNLOCK && sfr.wdata == NVAC_KEY2
                && unlockStep == 2'd1) begin
                unlockStep <= 2'd2;
            end else begin
                unlockStep <= 2'd0;
            end
        end
    end

    // Data, address and abort survive warm reset; only power-on clears them
    always_ff @(posedge clk or negedge porSync) begin
        if (!porSync) begin
            dataLo <= NVAC_RST_BYTE;
            dataHi <= '0;
        end else if (ce && rstSync) begin
            if (state == NVAC_READ) begin
                // Data space has no high byte, so a data read clears it
                dataLo <= spaceSel ? memRd[7:0] : memRd[7:0];
                dataHi <= spaceSel ? memRd[13:8] : 6'd0;
            end else if (sfrWr && !busy) begin
                if (sfr.addr == NVAC_OFS_DATA_LO) dataLo <= sfr.wdata;
                if (sfr.addr == NVAC_OFS_DATA_HI) dataHi <= sfr.wdata[5:0];
            end
        end
    end

    // Address pair is only ever written by software, never loaded by a read
    always_ff @(posedge clk or negedge porSync) begin
        if (!porSync) begin
            addrLo <= NVAC_RST_BYTE;
            addrHi <= '0;
        end else if (ce && rstSync && sfrWr && !busy) begin
            if (sfr.addr == NVAC_OFS_ADDR_LO) addrLo <= sfr.wdata;
            if (sfr.addr == NVAC_OFS_ADDR_HI) addrHi <= sfr.wdata[4:0];
        end
    end

    always_ff @(posedge clk or negedge porSync) begin
        if (!porSync) begin
            abortFlag <= 1'b0;
        end else if (!rstSync) begin
            if (busy) abortFlag <= 1'b1;
        end else if (ce) begin
            if (state == NVAC_DONE) begin
                abortFlag <= 1'b0;
            end else if (ctrlWr) begin
                abortFlag <= sfr.wdata[NVAC_BIT_ABORT];
            end
        end
    end

    always_ff @(posedge clk or negedge porSync) begin
        if (!porSync) begin
            writeAllow <= 1'b0;
        end else if (ce && ctrlWr) begin
            writeAllow <= sfr.wdata[NVAC_BIT_WALLOW];
        end
    end

    // Busy survives warm reset so the abort can be seen, then clears
    always_ff @(posedge clk or negedge porSync) begin
        if (!porSync) begin
            busy <= 1'b0;
        end else if (!rstSync) begin
            busy <= 1'b0;
        end else if (ce) begin
            busy <= state == NVAC_PROG || wrStart;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spaceSel <= 1'b0;
            eraseSel <= 1'b0;
        end else if (!rstSync) begin
            spaceSel <= 1'b0;
            eraseSel <= 1'b0;
        end else if (ce && ctrlWr && state == NVAC_IDLE) begin
            spaceSel <= sfr.wdata[NVAC_BIT_SPACE];
            eraseSel <= sfr.wdata[NVAC_BIT_ERASE];
        end
    end

    // Main sequencer: triggers are set-only and cleared here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= NVAC_IDLE;
            rdTrig <= 1'b0;
            wrTrig <= 1'b0;
            timer <= '0;
            rowIdx <= '0;
            pumpOn <= 1'b0;
        end else if (!rstSync) begin
            state <= NVAC_IDLE;
            rdTrig <= 1'b0;
            wrTrig <= 1'b0;
            timer <= '0;
            rowIdx <= '0;
            pumpOn <= 1'b0;
        end else if (ce) begin
            unique case (state)
                NVAC_IDLE: begin
                    if (wrStart) begin
                        wrTrig <= 1'b1;
                        timer <= '0;
                        rowIdx <= '0;
                        state <= NVAC_PROG;
                        pumpOn <= spaceSel ? progFires : dataImpl(addrLo);
                    end else if (ctrlWr && sfr.wdata[NVAC_BIT_RD]) begin
                        rdTrig <= 1'b1;
                        state <= NVAC_READ;
                    end
                end
                NVAC_READ: begin
                    rdTrig <= 1'b0;
                    state <= NVAC_IDLE;
                end
                NVAC_PROG: begin
                    // Erase steps through the whole row, a block write through four words
                    timer <= timer + 32'd1;
                    if (timerEnd) begin
                        timer <= '0;
                        if (spaceSel && eraseSel && rowIdx != 5'(NVAC_ROW_WORDS - 1)) begin
                            rowIdx <= rowIdx + 5'd1;
                        end else if (spaceSel && !eraseSel
                            && rowIdx != 5'(NVAC_BLOCK_WORDS - 1)) begin
                            rowIdx <= rowIdx + 5'd1;
                        end else begin
                            pumpOn <= 1'b0;
                            state <= NVAC_DONE;
                        end
                    end
                end
                NVAC_DONE: begin
                    wrTrig <= 1'b0;
                    state <= NVAC_IDLE;
                end
                default: state <= NVAC_IDLE;
            endcase
        end
    end

    // Program writes gather into a 4-word latch; the last word fires the block
    always_ff @(posedge clk) begin
        if (ce && wrStart && spaceSel && !eraseSel) begin
            latch[pAddr[1:0]] <= {dataHi, dataLo};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            doneFlag <= 1'b0;
        end else if (ce) begin
            if (state == NVAC_DONE) begin
                doneFlag <= 1'b1;
            end else if (sfrWr && sfr.addr == NVAC_OFS_FLAGS2 && !sfr.wdata[NVAC_BIT_DONE]) begin
                doneFlag <= 1'b0;
            end
        end
    end

    always_comb begin
        dMem = '0;
        pMem = '0;
        dMem.addr = BIG_DATA ? {4'd0, addrLo} : {5'd0, addrLo[6:0]};
        pMem.addr = {1'b0, pAddr};
        if (state == NVAC_PROG && timerEnd) begin
            dMem.we = !spaceSel && dataImpl(addrLo);
            dMem.wdata = {6'd0, dataLo};
            pMem.we = spaceSel && progFires;
            if (eraseSel) begin
                pMem.addr = {1'b0, pAddr[10:5], rowIdx};
                pMem.wdata = 14'h3FFF;
            end else begin
                pMem.addr = {1'b0, pAddr[10:2], rowIdx[1:0]};
                pMem.wdata = latch[rowIdx[1:0]];
            end
        end
        memRd = spaceSel ? pRd : (dataImpl(addrLo) ? {6'd0, dRd} : 14'd0);
    end

    nvac_store #(.AW(12), .DW(8)) dataStore (
        .clk(clk),
        .ce(ce),
        .we(dMem.we),
        .addr(dMem.addr),
        .wdata(dMem.wdata[7:0]),
        .rdata(dRd)
    );

    nvac_store #(.AW(12), .DW(14)) progStore (
        .clk(clk),
        .ce(ce),
        .we(pMem.we),
        .addr(pMem.addr),
        .wdata(pMem.wdata),
        .rdata(pRd)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= NVAC_RST_BYTE;
            extProgGrant <= 1'b0;
        end else if (ce) begin
            // Protection denies the outside programmer; the core loses only writes to protected blocks
            extProgGrant <= extProgRequest && !codeProtect;
            // Read data lags the bus address by one cycle
            unique case (sfr.addr)
                NVAC_OFS_CTRL: rdData <= {spaceSel, 2'b00, eraseSel, abortFlag,
                    writeAllow, wrTrig, rdTrig};
                NVAC_OFS_UNLOCK: rdData <= 8'h00;
                NVAC_OFS_DATA_LO: rdData <= dataLo;
                NVAC_OFS_DATA_HI: rdData <= {2'b00, dataHi};
                NVAC_OFS_ADDR_LO: rdData <= addrLo;
                NVAC_OFS_ADDR_HI: rdData <= {3'b000, addrHi};
                NVAC_OFS_FLAGS2: rdData <= {3'b000, doneFlag, 4'h0};
                default: rdData <= 8'h00;
            endcase
        end
    end
endmodule

// ==== nvac_top_assertions.sv ====
`timescale 1ns/10ps
module nvac_top_assertions
    import nvac_pkg::*;
#(
    parameter int WRITE_CYCLES = NVAC_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic ce,
    input wire nvac_sfr_t sfr,
    input wire logic codeProtect,
    input wire logic extProgRequest,
    input wire logic [7:0] rdData,
    input wire logic busy,
    input wire logic pumpOn,
    input wire logic doneFlag,
    input wire logic extProgGrant
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b || !por_b);

    int busyRun;
    logic [1:0] ctrlSeen;

    always_ff @(posedge clk or negedge por_b) begin
        if (!por_b) begin
            busyRun <= 0;
        end else begin
            busyRun <= busy ? busyRun + 1 : 0;
        end
    end

    // Last control write {space, allow}; cleared on any reset so the trigger check stays safe
    always_ff @(posedge clk or negedge por_b or negedge rst_b) begin
        if (!por_b || !rst_b) begin
            ctrlSeen <= 2'b00;
        end else if (ce && sfr.wr && sfr.addr == NVAC_OFS_CTRL) begin
            ctrlSeen <= {sfr.wdata[NVAC_BIT_SPACE], sfr.wdata[NVAC_BIT_WALLOW]};
        end
    end

    sequence keyOne;
        ce && sfr.wr && sfr.addr == NVAC_OFS_UNLOCK && sfr.wdata == NVAC_KEY1;
    endsequence
    sequence keyTwo;
        ce && sfr.wr && sfr.addr == NVAC_OFS_UNLOCK && sfr.wdata == NVAC_KEY2;
    endsequence
    sequence goData;
        ce && sfr.wr && sfr.addr == NVAC_OFS_CTRL && sfr.wdata[NVAC_BIT_WR] && !busy
            && ctrlSeen == 2'b01 && !sfr.wdata[NVAC_BIT_SPACE];
    endsequence

    chk_key_starts_write: assert property (keyOne ##1 keyTwo ##1 goData |=> busy)
        else $error("unlocked write trigger did not start a cycle");
    chk_busy_has_cause: assert property ($rose(busy) |->
        $past(sfr.wr && sfr.addr == NVAC_OFS_CTRL && sfr.wdata[NVAC_BIT_WR]))
        else $error("programming cycle started without a write trigger");
    chk_busy_run_bound: assert property (busyRun <= NVAC_ROW_WORDS * WRITE_CYCLES + 1)
        else $error("programming cycle ran past the timer");
    chk_pump_in_cycle: assert property (pumpOn |-> busy)
        else $error("pump on outside a programming cycle");
    chk_done_after_busy: assert property ($rose(doneFlag) |-> $past(busy) || $past(busy, 2))
        else $error("done flag rose without a finished cycle");
    chk_busy_end_done: assert property ($fell(busy) |-> ##[0:1] doneFlag)
        else $error("cycle ended without done flag");
    chk_done_stays_set: assert property (doneFlag && !(sfr.wr && sfr.addr == NVAC_OFS_FLAGS2)
        |=> doneFlag)
        else $error("done flag cleared without software");
    chk_ce_low_freezes: assert property (!ce |=> $stable(busy) && $stable(doneFlag))
        else $error("state moved while clock enable low");
    chk_unlock_reads_zero: assert property ($past(ce) && $past(sfr.addr) == NVAC_OFS_UNLOCK
        |-> rdData == 8'h00)
        else $error("unlock port read non-zero");
    chk_grant_unprotected: assert property (extProgGrant |->
        $past(extProgRequest && !codeProtect))
        else $error("external access granted under protection");
endmodule

bind nvac_top nvac_top_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
    .clk(clk),
    .rst_b(rst_b),
    .por_b(por_b),
    .ce(ce),
    .sfr(sfr),
    .codeProtect(codeProtect),
    .extProgRequest(extProgRequest),
    .rdData(rdData),
    .busy(busy),
    .pumpOn(pumpOn),
    .doneFlag(doneFlag),
    .extProgGrant(extProgGrant)
);

// ==== nvac_top_tb.sv ====
`timescale 1ns/10ps
module nvac_top_tb;
    import nvac_pkg::*;
    localparam int WC = 4;
    logic clk, rst_b, por_b, ce, codeProtect, extProgRequest, pumpSeen;
    logic [3:0] blockProtect;
    nvac_sfr_t sfr;
    logic [7:0] rdData, rv;
    logic busy, pumpOn, doneFlag, extProgGrant;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int n;

    nvac_top #(.BIG_DATA(1'b0), .BIG_PROG(1'b0), .WRITE_CYCLES(WC)) uut (
        .clk(clk),
        .rst_b(rst_b),
        .por_b(por_b),
        .ce(ce),
        .sfr(sfr),
        .codeProtect(codeProtect),
        .blockProtect(blockProtect),
        .extProgRequest(extProgRequest),
        .rdData(rdData),
        .busy(busy),
        .pumpOn(pumpOn),
        .doneFlag(doneFlag),
        .extProgGrant(extProgGrant)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask

    // Strobe stays up between back-to-back writes; idle() drops it
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        sfr.wr = 1'b1;
        sfr.addr = a;
        sfr.wdata = d;
        @(negedge clk);
    endtask

    task automatic idle();
        sfr.wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [8:0] a);
        sfr.wr = 1'b0;
        sfr.addr = a;
        @(negedge clk);
        rv = rdData;
    endtask

    // Counts busy cycles; gives up quickly when no cycle starts
    task automatic waitDone();
        n = 0;
        pumpSeen = 1'b0;
        for (int i = 0; i < 400; i++) begin
            if (pumpOn === 1'b1) pumpSeen = 1'b1;
            if (busy === 1'b1) n++;
            else if (n > 0 || i > 3) break;
            @(negedge clk);
        end
        @(negedge clk);
    endtask

    task automatic go(input logic [7:0] v);
        wr(NVAC_OFS_CTRL, v);
        wr(NVAC_OFS_UNLOCK, NVAC_KEY1);
        wr(NVAC_OFS_UNLOCK, NVAC_KEY2);
        wr(NVAC_OFS_CTRL, v | 8'h02);
        idle();
        waitDone();
    endtask

    task automatic readBack(input logic [7:0] v, input logic [8:0] a);
        wr(NVAC_OFS_CTRL, v | 8'h01);
        idle();
        repeat (2) @(negedge clk);
        rd(a);
    endtask

    task automatic t_reset();
        rd(NVAC_OFS_CTRL);
        cmp8(rv & 8'h87, 8'h00);
        rd(NVAC_OFS_UNLOCK);
        cmp8(rv, 8'h00);
        cmp1(doneFlag, 1'b0);
        ce = 1'b0;
        wr(NVAC_OFS_CTRL, 8'h04);
        idle();
        ce = 1'b1;
        rd(NVAC_OFS_CTRL);
        cmp8(rv & 8'h04, 8'h00);
    endtask

    task automatic t_refuse();
        wr(NVAC_OFS_UNLOCK, NVAC_KEY1);
        wr(NVAC_OFS_UNLOCK, NVAC_KEY2);
        wr(NVAC_OFS_CTRL, 8'h02);
        idle();
        waitDone();
        cmp8(8'(n), 8'h00);
        wr(NVAC_OFS_CTRL, 8'h04);
        wr(NVAC_OFS_CTRL, 8'h06);
        idle();
        waitDone();
        cmp8(8'(n), 8'h00);
        rd(NVAC_OFS_CTRL);
        cmp8(rv & 8'h02, 8'h00);
    endtask

    task automatic t_data();
        wr(NVAC_OFS_ADDR_LO, 8'h12);
        wr(NVAC_OFS_DATA_LO, 8'hA5);
        go(8'h04);
        cmp8(8'(n), 8'(WC));
        cmp1(pumpSeen, 1'b1);
        cmp1(doneFlag, 1'b1);
        rd(NVAC_OFS_CTRL);
        cmp8(rv & 8'h0A, 8'h00);
        rd(NVAC_OFS_UNLOCK);
        cmp8(rv, 8'h00);
        wr(NVAC_OFS_FLAGS2, 8'h00);
        idle();
        cmp1(doneFlag, 1'b0);
        wr(NVAC_OFS_DATA_LO, 8'h00);
        readBack(8'h04, NVAC_OFS_DATA_LO);
        cmp8(rv, 8'hA5);
        rd(NVAC_OFS_CTRL);
        cmp8(rv & 8'h01, 8'h00);
        wr(NVAC_OFS_ADDR_LO, 8'h92);
        wr(NVAC_OFS_DATA_LO, 8'h3C);
        go(8'h04);
        cmp1(pumpSeen, 1'b0);
        readBack(8'h04, NVAC_OFS_DATA_LO);
        cmp8(rv, 8'h00);
    endtask

    task automatic t_prog();
        wr(NVAC_OFS_ADDR_HI, 8'h00);
        wr(NVAC_OFS_ADDR_LO, 8'h20);
        go(8'h94);
        cmp8(8'(n), 8'(NVAC_ROW_WORDS * WC));
        for (int i = 0; i < NVAC_BLOCK_WORDS; i++) begin
            wr(NVAC_OFS_ADDR_LO, 8'h20 + 8'(i));
            wr(NVAC_OFS_DATA_HI, 8'h25);
            wr(NVAC_OFS_DATA_LO, 8'hC0 + 8'(i));
            go(8'h84);
        end
        // 0x422 lies past 1K words and must land on 0x022
        wr(NVAC_OFS_ADDR_HI, 8'h04);
        wr(NVAC_OFS_ADDR_LO, 8'h22);
        readBack(8'h84, NVAC_OFS_DATA_LO);
        cmp8(rv, 8'hC2);
        rd(NVAC_OFS_DATA_HI);
        cmp8(rv, 8'h25);
        wr(NVAC_OFS_ADDR_LO, 8'h3F);
        readBack(8'h84, NVAC_OFS_DATA_LO);
        cmp8(rv, 8'hFF);
        rd(NVAC_OFS_DATA_HI);
        cmp8(rv, 8'h3F);
    endtask

    task automatic t_abort();
        wr(NVAC_OFS_CTRL, 8'h04);
        wr(NVAC_OFS_ADDR_LO, 8'h12);
        wr(NVAC_OFS_DATA_LO, 8'h5A);
        wr(NVAC_OFS_UNLOCK, NVAC_KEY1);
        wr(NVAC_OFS_UNLOCK, NVAC_KEY2);
        wr(NVAC_OFS_CTRL, 8'h06);
        wr(NVAC_OFS_CTRL, 8'h04);
        rd(NVAC_OFS_CTRL);
        cmp8(rv & 8'h02, 8'h02);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        rd(NVAC_OFS_CTRL);
        cmp8(rv & 8'h08, 8'h08);
        rd(NVAC_OFS_ADDR_LO);
        cmp8(rv, 8'h12);
        rd(NVAC_OFS_DATA_LO);
        cmp8(rv, 8'h5A);
        go(8'h0C);
        rd(NVAC_OFS_CTRL);
        cmp8(rv & 8'h08, 8'h00);
        readBack(8'h04, NVAC_OFS_DATA_LO);
        cmp8(rv, 8'h5A);
    endtask

    task automatic t_protect();
        extProgRequest = 1'b1;
        codeProtect = 1'b1;
        repeat (2) @(negedge clk);
        cmp1(extProgGrant, 1'b0);
        codeProtect = 1'b0;
        repeat (2) @(negedge clk);
        cmp1(extProgGrant, 1'b1);
        extProgRequest = 1'b0;
        codeProtect = 1'b1;
        blockProtect = 4'h1;
        wr(NVAC_OFS_ADDR_HI, 8'h00);
        wr(NVAC_OFS_ADDR_LO, 8'h23);
        go(8'h84);
        cmp1(pumpSeen, 1'b0);
        readBack(8'h84, NVAC_OFS_DATA_LO);
        cmp8(rv, 8'hC3);
        codeProtect = 1'b0;
    endtask

    initial begin
        rst_b = 1'b0;
        por_b = 1'b0;
        ce = 1'b1;
        codeProtect = 1'b0;
        extProgRequest = 1'b0;
        blockProtect = 4'h0;
        sfr = '0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        por_b = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_refuse();
        t_data();
        t_prog();
        t_abort();
        t_protect();
        wrap_up();
    end
endmodule
